/* File: rtl/eesi_pkg.sv */
// shared constants and types for the serial eeprom slave interface and its bus master
// Notes on behaviour
// - array holds 4096, 8192 or 16384 bytes
// - select byte upper nibble must match type
// - select bits b3..b1 match chip-select straps
// - floating strap reads as logic zero
// - select byte msb first, b0 is direction
// - device acknowledges each written byte, ninth slot
// - master acknowledges each read byte but the last, ninth slot
// - write ends stop after ack, read after nack
// - start opens every operation; serial clock times all
// - write-inhibit high from start to address end blocks array modification
// - floating write-inhibit reads low, writes allowed
// - inhibited: select, address acked; data not acked
// - data line only pulled low or released
// - held in standby reset until supply valid
// - supply drop re-enters reset, bus ignored
// - stop enters standby unless write cycle runs
// - sixteen-bit address, high byte then low
// - stop after write starts timed cycle; bus ignored
package eesi_pkg;

    // system clock and internal write cycle length
    localparam int CLK_MHZ = 50;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;

    // bit counter marks within a nine-slot byte
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    // master register offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_TX = 8'h04;
    localparam logic [7:0] REG_RX = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_DIV = 8'h10;

    // command register fields
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_WRITE = 2;
    localparam int CMD_READ = 3;
    localparam int CMD_NACK = 4;

    // status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_ACK = 1;

    // quarter bit time in clock cycles minus one, after reset
    localparam logic [7:0] DIV_RESET = 8'h05;

    typedef enum logic [2:0] {
        DS_IDLE, DS_SEL, DS_ADDR_HI, DS_ADDR_LO, DS_WDATA, DS_RDATA, DS_BUSY
    } eesi_dev_state_e;

    typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} eesi_mst_state_e;

endpackage : eesi_pkg

/* File: rtl/eesi_if.sv */
// two-wire link between the eeprom slave and its bus master
`timescale 1ns/1ns
`default_nettype none
interface eesi_if;
    logic scl;
    logic sda_dev_out;
    logic sda_dev_oe;
    logic sda_mst_out;
    logic sda_mst_oe;
    logic sda;

    // wired-and with an implied pull-up
    assign sda = !((sda_dev_oe && !sda_dev_out) || (sda_mst_oe && !sda_mst_out));

    modport device(input scl, input sda, output sda_dev_out, output sda_dev_oe);
    modport master(output scl, output sda_mst_out, output sda_mst_oe, input sda);
endinterface : eesi_if
`default_nettype wire

/* File: rtl/eesi_sync.sv */
// two-flop synchroniser with edge pulses on the synchronised value
`timescale 1ns/1ns
`default_nettype none
module eesi_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
        logic [W-1:0] prev;
    } eesi_sync_s;

    eesi_sync_s r_reg;
    eesi_sync_s r_next;

    // edges come from second and third stage only, never the first
    always_comb begin
        r_next.meta = d_i;
        r_next.q = r_reg.meta;
        r_next.prev = r_reg.q;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q_o = r_reg.q;
    assign rise_o = r_reg.q & ~r_reg.prev;
    assign fall_o = ~r_reg.q & r_reg.prev;
endmodule : eesi_sync
`default_nettype wire

/* File: rtl/eesi_device.sv */
// serial eeprom slave: select decode, address, page buffer, timed write and read
`timescale 1ns/1ns
`default_nettype none
module eesi_device #(
    parameter int DEPTH = 16384,
    parameter int PAGE = 64,
    parameter int WRITE_CNT = eesi_pkg::WRITE_CYCLES,
    // arbitrary type code, not tied to any real part
    parameter logic [3:0] TYPE_CODE = 4'h9
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    eesi_if.device bus,
    input wire logic chip_select_strap_0_i,
    input wire logic chip_select_strap_1_i,
    input wire logic chip_select_strap_2_i,
    input wire logic write_inhibit_input_i,
    input wire logic supply_ok_i,
    output logic standby_o,
    output logic write_busy_o
);
    import eesi_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(PAGE);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        eesi_dev_state_e st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [15:0] addr;
        logic pull;
        logic mack;
        logic wp;
        logic [PAGE-1:0] pend;
        logic [PW-1:0] idx;
        logic [31:0] timer;
    } eesi_dev_s;

    localparam eesi_dev_s DEV_RST = '0;

    eesi_dev_s r_reg;
    eesi_dev_s r_next;

    // array sized by variant; only low address bits index it
    logic [7:0] mem [DEPTH];
    logic [7:0] pbuf [PAGE];

    logic buf_we;
    logic [7:0] mem_rd;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [6:0] pin_q;
    logic [6:0] pin_rise;
    logic [6:0] pin_fall;

    // straps and inhibit are pins too, so they are synchronised as well
    eesi_sync #(
        .W(7)
    ) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({supply_ok_i, write_inhibit_input_i, chip_select_strap_2_i,
              chip_select_strap_1_i, chip_select_strap_0_i, bus.sda, bus.scl}),
        .q_o(pin_q),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [2:0] straps;
    logic inhibit;
    logic supply_ok;
    logic sel_match;

    // sda edges while scl is high frame a transfer
    assign scl = pin_q[0];
    assign sda = pin_q[1];
    assign scl_rise = pin_rise[0];
    assign scl_fall = pin_fall[0];
    assign start_seen = pin_fall[1] & scl;
    assign stop_seen = pin_rise[1] & scl;
    assign straps = pin_q[4:2];
    assign inhibit = pin_q[5];
    assign supply_ok = pin_q[6];

    // type nibble and strap address must both agree
    assign sel_match = (r_reg.sh[7:4] == TYPE_CODE)
                     && (r_reg.sh[3:1] == straps);

    // read port follows the address counter; upper bits dropped
    assign mem_rd = mem[r_reg.addr[AW-1:0]];

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_next = r_reg;
        buf_we = 1'b0;
        if (!supply_ok) begin
            // no response at all below the supply threshold
            r_next = DEV_RST;
        end else if (r_reg.st == DS_BUSY) begin
            // bus ignored entirely while the write cycle runs
            r_next.pull = 1'b0;
            r_next.idx = r_reg.idx + 1'b1;
            if (r_reg.timer == 32'h0) begin
                r_next.st = DS_IDLE;
                r_next.pend = '0;
            end else begin
                r_next.timer = r_reg.timer - 32'h1;
            end
        end else if (stop_seen) begin
            r_next.pull = 1'b0;
            // stop in the tenth slot: its clock rise is already counted
            if (r_reg.st == DS_WDATA && r_reg.bits == 4'h1 && |r_reg.pend) begin
                r_next.st = DS_BUSY;
                r_next.timer = 32'(WRITE_CNT - 1);
                r_next.idx = '0;
            end else begin
                r_next.st = DS_IDLE;
                r_next.pend = '0;
            end
        end else if (start_seen) begin
            // repeated start keeps the address counter for random reads
            r_next.st = DS_SEL;
            r_next.bits = 4'h0;
            r_next.pull = 1'b0;
            r_next.pend = '0;
            r_next.wp = inhibit;
        end else if (r_reg.st != DS_IDLE && scl_rise) begin
            // sample on the rising serial clock edge
            r_next.bits = r_reg.bits + 4'h1;
            if (r_reg.st == DS_RDATA) begin
                if (r_reg.bits == BIT_ACK) begin
                    r_next.mack = ~sda;
                end
            end else if (r_reg.bits != BIT_ACK) begin
                r_next.sh = {r_reg.sh[6:0], sda};
            end
            // inhibit level counts from start to the end of the address
            if (r_reg.st == DS_SEL || r_reg.st == DS_ADDR_HI || r_reg.st == DS_ADDR_LO) begin
                r_next.wp = r_reg.wp | inhibit;
            end
        end else if (r_reg.st != DS_IDLE && scl_fall) begin
            // all driving changes while the serial clock is low
            if (r_reg.st == DS_RDATA) begin
                if (r_reg.bits == BIT_DONE) begin
                    r_next.bits = 4'h0;
                    if (r_reg.mack) begin
                        r_next.sh = mem_rd;
                        r_next.pull = ~mem_rd[7];
                        r_next.addr = r_reg.addr + 16'h1;
                    end else begin
                        // no ack from master: release and wait for stop
                        r_next.st = DS_IDLE;
                        r_next.pull = 1'b0;
                    end
                end else if (r_reg.bits == BIT_ACK) begin
                    r_next.pull = 1'b0;
                end else begin
                    r_next.sh = {r_reg.sh[6:0], 1'b0};
                    r_next.pull = ~r_reg.sh[6];
                end
            end else if (r_reg.bits == BIT_ACK) begin
                // ninth slot: decide whether to acknowledge
                case (r_reg.st)
                    DS_SEL: begin
                        if (sel_match) begin
                            r_next.pull = 1'b1;
                        end else begin
                            r_next.st = DS_IDLE;
                        end
                    end
                    DS_ADDR_HI: begin
                        r_next.pull = 1'b1;
                        r_next.addr[15:8] = r_reg.sh;
                    end
                    DS_ADDR_LO: begin
                        r_next.pull = 1'b1;
                        r_next.addr[7:0] = r_reg.sh;
                    end
                    DS_WDATA: begin
                        if (!r_reg.wp) begin
                            r_next.pull = 1'b1;
                            buf_we = 1'b1;
                            r_next.pend[r_reg.addr[PW-1:0]] = 1'b1;
                            // address rolls over inside the page
                            r_next.addr[PW-1:0] = r_reg.addr[PW-1:0] + 1'b1;
                        end else begin
                            r_next.pull = 1'b0;
                        end
                    end
                    default: begin
                        r_next.pull = 1'b0;
                    end
                endcase
            end else if (r_reg.bits == BIT_DONE) begin
                // end of ack slot: release, or drive the first bit after a read select, and move on
                r_next.bits = 4'h0;
                r_next.pull = 1'b0;
                case (r_reg.st)
                    DS_SEL: begin
                        if (r_reg.sh[0]) begin
                            r_next.st = DS_RDATA;
                            r_next.sh = mem_rd;
                            r_next.pull = ~mem_rd[7];
                            r_next.addr = r_reg.addr + 16'h1;
                        end else begin
                            r_next.st = DS_ADDR_HI;
                        end
                    end
                    DS_ADDR_HI: begin
                        r_next.st = DS_ADDR_LO;
                    end
                    DS_ADDR_LO: begin
                        r_next.st = DS_WDATA;
                    end
                    default: begin
                        r_next.st = r_reg.st;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            r_reg <= DEV_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // page buffer collects data so an aborted write leaves the array alone
    always_ff @(posedge clk_i) begin
        if (buf_we) begin
            pbuf[r_reg.addr[PW-1:0]] <= r_reg.sh;
        end
    end

    // commit one pending byte per cycle inside the timed window
    always_ff @(posedge clk_i) begin
        if (nrst_i && supply_ok && r_reg.st == DS_BUSY && r_reg.pend[r_reg.idx]) begin
            mem[{r_reg.addr[AW-1:PW], r_reg.idx}] <= pbuf[r_reg.idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // open drain: the level driven is always low
    assign bus.sda_dev_out = 1'b0;
    assign bus.sda_dev_oe = r_reg.pull;
    assign standby_o = (r_reg.st == DS_IDLE);
    assign write_busy_o = (r_reg.st == DS_BUSY);
endmodule : eesi_device
`default_nettype wire

/* File: rtl/eesi_master.sv */
// two-wire bus master driven by a small software register file
`timescale 1ns/1ns
`default_nettype none
module eesi_master (
    input wire logic clk_i,
    input wire logic nrst_i,
    eesi_if.master bus,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o
);
    import eesi_pkg::*;

    typedef struct packed {
        eesi_mst_state_e st;
        logic [1:0] ph;
        logic [3:0] nbit;
        logic [8:0] sh;
        logic [8:0] rx;
        logic scl;
        logic pull;
        logic start_p;
        logic stop_p;
        logic byte_p;
        logic rd_op;
        logic nack;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic ack;
        logic [7:0] div;
        logic [7:0] cnt;
        logic [31:0] rdata;
    } eesi_mst_s;

    eesi_mst_s r_reg;
    eesi_mst_s r_next;

    logic sda;
    logic busy;
    logic tick;

    // returned data line is a pin, so synchronise it
    eesi_sync #(
        .W(1)
    ) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i(bus.sda),
        .q_o(sda),
        .rise_o(),
        .fall_o()
    );

    assign busy = (r_reg.st != MS_IDLE) | r_reg.start_p | r_reg.byte_p | r_reg.stop_p;
    assign tick = (r_reg.cnt == 8'h0);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_next = r_reg;
        // divider: one tick per quarter bit
        r_next.cnt = tick ? r_reg.div : r_reg.cnt - 8'h1;
        // commands are only taken while idle; otherwise dropped
        if (wr_i && addr_i == REG_CMD && !busy) begin
            r_next.start_p = wdata_i[CMD_START];
            r_next.stop_p = wdata_i[CMD_STOP];
            r_next.byte_p = wdata_i[CMD_WRITE] | wdata_i[CMD_READ];
            r_next.rd_op = wdata_i[CMD_READ];
            r_next.nack = wdata_i[CMD_NACK];
        end else if (wr_i && addr_i == REG_TX) begin
            r_next.txd = wdata_i[7:0];
        end else if (wr_i && addr_i == REG_DIV) begin
            r_next.div = wdata_i[7:0];
        end
        // read data stand in the cycle after the strobe
        case (addr_i)
            REG_CMD: r_next.rdata = {27'h0, r_reg.nack, r_reg.rd_op, r_reg.byte_p,
                                     r_reg.stop_p, r_reg.start_p};
            REG_TX: r_next.rdata = {24'h0, r_reg.txd};
            REG_RX: r_next.rdata = {24'h0, r_reg.rxd};
            REG_STATUS: r_next.rdata = {30'h0, r_reg.ack, busy};
            REG_DIV: r_next.rdata = {24'h0, r_reg.div};
            default: r_next.rdata = 32'h0;
        endcase
        if (!rd_i) begin
            r_next.rdata = 32'h0;
        end
        if (tick) begin
            r_next.ph = r_reg.ph + 2'h1;
            case (r_reg.st)
                MS_IDLE: begin
                    r_next.ph = 2'h0;
                    if (r_reg.start_p) begin
                        r_next.st = MS_START;
                    end else if (r_reg.byte_p) begin
                        r_next.st = MS_BIT;
                        r_next.nbit = 4'h0;
                        // master acks a read byte unless told to end
                        r_next.sh = r_reg.rd_op ? {8'hff, r_reg.nack} : {r_reg.txd, 1'b1};
                    end else if (r_reg.stop_p) begin
                        r_next.st = MS_STOP;
                    end
                end
                MS_START: begin
                    // works for a repeated start from scl low as well
                    case (r_reg.ph)
                        2'h0: r_next.pull = 1'b0;
                        2'h1: r_next.scl = 1'b1;
                        2'h2: r_next.pull = 1'b1;
                        default: begin
                            r_next.scl = 1'b0;
                            r_next.st = MS_IDLE;
                            r_next.start_p = 1'b0;
                        end
                    endcase
                end
                MS_BIT: begin
                    case (r_reg.ph)
                        2'h0: r_next.pull = ~r_reg.sh[8];
                        2'h1: r_next.scl = 1'b1;
                        2'h2: r_next.rx = {r_reg.rx[7:0], sda};
                        default: begin
                            r_next.scl = 1'b0;
                            r_next.sh = {r_reg.sh[7:0], 1'b1};
                            r_next.nbit = r_reg.nbit + 4'h1;
                            if (r_reg.nbit == BIT_ACK) begin
                                r_next.rxd = r_reg.rx[8:1];
                                r_next.ack = ~r_reg.rx[0];
                                r_next.byte_p = 1'b0;
                                r_next.st = MS_IDLE;
                            end
                        end
                    endcase
                end
                MS_STOP: begin
                    case (r_reg.ph)
                        2'h0: r_next.pull = 1'b1;
                        2'h1: r_next.scl = 1'b1;
                        2'h2: r_next.pull = 1'b0;
                        default: begin
                            r_next.st = MS_IDLE;
                            r_next.stop_p = 1'b0;
                        end
                    endcase
                end
                default: begin
                    r_next.st = MS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            r_reg <= '{st: MS_IDLE, scl: 1'b1, div: DIV_RESET, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // serial clock is push-pull; data is open drain like the slave's
    assign bus.scl = r_reg.scl;
    assign bus.sda_mst_out = 1'b0;
    assign bus.sda_mst_oe = r_reg.pull;
    assign rdata_o = r_reg.rdata;
endmodule : eesi_master
`default_nettype wire

/* File: sim/eesi_monitor.sv */
// assertion checker watching the two-wire link between the eeprom ends
`timescale 1ns/1ns
`default_nettype none
module eesi_monitor
    import eesi_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = 4'h9
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_out,
    input wire logic sda_dev_oe,
    input wire logic sda_mst_out,
    input wire logic sda_mst_oe
);
    logic scl_q, sda_q, first_reg, idle_reg, miss_reg, start, stop, rise;
    logic [3:0] slot_reg;
    logic [7:0] sel_reg;
    // frame edges seen straight on the pins; the master drives them from registers
    assign start = scl && scl_q && sda_q && !sda;
    assign stop = scl && scl_q && !sda_q && sda;
    assign rise = scl && !scl_q;
    // slot count, select byte capture and idle flag
    always_ff @(posedge clk_i) begin
        scl_q <= scl;
        sda_q <= sda;
        if (!nrst_i) begin
            slot_reg <= 4'h0;
            first_reg <= 1'b0;
            idle_reg <= 1'b1;
            miss_reg <= 1'b0;
            sel_reg <= 8'h00;
        end else if (start) begin
            slot_reg <= 4'h0;
            first_reg <= 1'b1;
            idle_reg <= 1'b0;
            miss_reg <= 1'b0;
        end else if (stop) begin
            idle_reg <= 1'b1;
        end else if (rise) begin
            slot_reg <= (slot_reg == BIT_ACK) ? 4'h0 : slot_reg + 4'h1;
            if (first_reg && slot_reg < BIT_ACK) sel_reg <= {sel_reg[6:0], sda};
            if (first_reg && slot_reg == BIT_ACK) first_reg <= 1'b0;
            if (first_reg && slot_reg == BIT_ACK) miss_reg <= sel_reg[7:4] != TYPE_CODE;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    chk_dev_open_drain:
        assert property (!sda_dev_out) else $error("device drives data high");
    chk_dev_reset_quiet:
        assert property ($rose(nrst_i) |-> !sda_dev_oe ##1 !sda_dev_oe) else $error("pull at reset");
    chk_dev_scl_low:
        assert property ($changed(sda_dev_oe) |-> !scl) else $error("data moved with clock high");
    chk_dev_answer_lag:
        assert property ($fell(scl) |=> $stable(sda_dev_oe)[*2]) else $error("answer too early");
    chk_idle_no_pull:
        assert property (idle_reg |-> !sda_dev_oe) else $error("pull while bus idle");
    chk_sel_ack_slot:
        assert property (first_reg && rise && sda_dev_oe |-> slot_reg == BIT_ACK) else $error("sel pull");
    chk_type_miss:
        assert property (miss_reg |-> !sda_dev_oe) else $error("answered foreign type");
    chk_write_ack_slot:
        assert property (!first_reg && !idle_reg && !sel_reg[0] && rise && sda_dev_oe
            |-> slot_reg == BIT_ACK) else $error("write pull outside ack slot");
endmodule : eesi_monitor
`default_nettype wire

/* File: sim/test_eesi.sv */
// self-checking bench: master and eeprom slave joined over the two-wire link
`timescale 1ns/1ns
`default_nettype none
module test_eesi;
    import eesi_pkg::*;
    localparam logic [3:0] TYPE = 4'h9; // arbitrary type code
    localparam logic [4:0] ST = 5'(1 << CMD_START);
    localparam logic [4:0] SP = 5'(1 << CMD_STOP);
    localparam logic [4:0] WB = 5'(1 << CMD_WRITE);
    localparam logic [4:0] RB = 5'(1 << CMD_READ);
    localparam logic [4:0] NK = 5'(1 << CMD_NACK);
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [2:0] strap = 3'h5;
    logic inhibit = 1'b0;
    logic supply_ok = 1'b1;
    logic standby_o;
    logic write_busy_o;
    logic ack;
    logic [7:0] b;
    int num_errors = 0;
    int total_checks = 0;
    eesi_if link ();
    eesi_device #(.WRITE_CNT(200), .TYPE_CODE(TYPE)) eesi_device_inst (.clk_i(clk_i),
        .nrst_i(nrst_i), .bus(link), .chip_select_strap_0_i(strap[0]),
        .chip_select_strap_1_i(strap[1]), .chip_select_strap_2_i(strap[2]),
        .write_inhibit_input_i(inhibit), .supply_ok_i(supply_ok), .standby_o(standby_o),
        .write_busy_o(write_busy_o));
    eesi_master eesi_master_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus(link), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    eesi_monitor #(.TYPE_CODE(TYPE)) eesi_monitor_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .scl(link.scl), .sda(link.sda), .sda_dev_out(link.sda_dev_out),
        .sda_dev_oe(link.sda_dev_oe), .sda_mst_out(link.sda_mst_out),
        .sda_mst_oe(link.sda_mst_oe));
    // 50 MHz clock
    always #10 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    // register port cycles; a clear edge between strobes keeps one assignment per step
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : reg_rd
    // one byte on the link, polled to completion under a bound
    task automatic op(input logic [4:0] cmd, input logic [7:0] tx);
        logic [31:0] s;
        int n;
        reg_wr(REG_TX, {24'h0, tx});
        reg_wr(REG_CMD, {27'h0, cmd});
        for (n = 0; n < 3000; n++) begin
            reg_rd(REG_STATUS, s);
            if (s[STAT_BUSY] === 1'b0) break;
        end
        if (n == 3000) begin
            num_errors++;
            $display("Error %0t: master stuck", $time);
            results();
        end
        ack = s[STAT_ACK];
        reg_rd(REG_RX, s);
        b = s[7:0];
    endtask : op
    task automatic head(input logic [15:0] a);
        op(ST | WB, {TYPE, strap, 1'b0});
        check(8'(ack), 8'h1);
        op(WB, a[15:8]);
        check(8'(ack), 8'h1);
        op(WB, a[7:0]);
        check(8'(ack), 8'h1);
    endtask : head
    task automatic read_at(input logic [15:0] a);
        head(a);
        op(ST | WB, {TYPE, strap, 1'b1});
        check(8'(ack), 8'h1);
        op(RB | NK | SP, 8'h00);
    endtask : read_at
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_write_read();
        int n;
        head(16'h4123);
        op(WB, 8'h5a);
        check(8'(ack), 8'h1);
        op(WB | SP, 8'hc3);
        check(8'(write_busy_o), 8'h1);
        op(ST | WB | SP, {TYPE, strap, 1'b0});
        check(8'(ack), 8'h0);
        for (n = 0; n < 1000 && write_busy_o !== 1'b0; n++) @(posedge clk_i);
        check(8'(write_busy_o), 8'h0);
        if (n == 1000) results();
        read_at(16'h0123);
        check(b, 8'h5a);
        read_at(16'h0124);
        check(b, 8'hc3);
        check(8'(standby_o), 8'h1);
        $display("test write_read done");
    endtask : t_write_read
    // every strap code answered, one flipped strap bit and a foreign type not
    task automatic t_select();
        int i;
        for (i = 0; i < 8; i++) begin
            @(posedge clk_i);
            strap <= i[2:0];
            op(ST | WB | SP, {TYPE, i[2:0], 1'b0});
            check(8'(ack), 8'h1);
            op(ST | WB | SP, {TYPE, i[2:0] ^ 3'(1 << (i % 3)), 1'b0});
            check(8'(ack), 8'h0);
        end
        op(ST | WB | SP, {TYPE ^ 4'h8, strap, 1'b0});
        check(8'(ack), 8'h0);
        $display("test select done");
    endtask : t_select
    task automatic t_inhibit();
        @(posedge clk_i);
        inhibit <= 1'b1;
        head(16'h0123);
        op(WB | SP, 8'h11);
        check(8'(ack), 8'h0);
        check(8'(write_busy_o), 8'h0);
        @(posedge clk_i);
        inhibit <= 1'b0;
        read_at(16'h0123);
        check(b, 8'h5a);
        $display("test inhibit done");
    endtask : t_inhibit
    task automatic t_supply();
        @(posedge clk_i);
        supply_ok <= 1'b0;
        repeat (4) @(posedge clk_i);
        check(8'(standby_o), 8'h1);
        op(ST | WB | SP, {TYPE, strap, 1'b0});
        check(8'(ack), 8'h0);
        @(posedge clk_i);
        supply_ok <= 1'b1;
        repeat (4) @(posedge clk_i);
        op(ST | WB | SP, {TYPE, strap, 1'b0});
        check(8'(ack), 8'h1);
        $display("test supply done");
    endtask : t_supply
    // reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_write_read();
        t_select();
        t_inhibit();
        t_supply();
        results();
    end
endmodule : test_eesi
`default_nettype wire
